// ---- hw/olduty_curve.sv ----
`default_nettype none
// What this block does
// - Begin threshold code is an input duty of code over 512.
// - Halt threshold code times two over 512 is the halt input duty.
// - Top threshold is code plus 257, over 512.
// - Floor output register is the minimum output duty, code over 512.
// - First gain code over 1024 is output percent per input percent.
// - No maximum output register; it follows from thresholds and slope.
// - Speed command is resolved to nine bits at most.
// - Coarser command at high PWM input rates drops command low bits.
// - Coarser output at high PWM output rates drops output low bits.
// - With pass-through set, output equals input at or above top.
// - Pass-through entry and exit use a programmable hysteresis.
// - Exit point is top minus (hysteresis code plus one) times two.
// - Plain mode: zero up to halt; band gives zero rising, floor falling.
// - Keep-turning alone: floor output for every command up to begin.
// - Full-on: zero command gives max curve or full; keep extends to halt.
// - Knee code times two over 512 is the knee input duty.
// - Above knee second gain applies, continuing from the knee output.
// - Knee, pass-through and below-begin options work together.
// - Parameters sit in registers loaded from store or written by host.
// - Open-loop select one maps duty; zero leaves closed-loop control.
module olduty_curve
(
   input wire logic clk_in,
   input wire logic reset_in,
   input wire logic [8:0] speed_command_in,
   input wire logic [1:0] cmd_lsb_drop_in,
   input wire logic [1:0] out_lsb_drop_in,
   input wire logic host_wr_en_in,
   input wire logic [7:0] host_addr_in,
   input wire logic [7:0] host_wr_data_in,
   input wire logic [7:0] host_rd_addr_in,
   input wire logic store_load_en_in,
   input wire logic [7:0] store_load_addr_in,
   input wire logic [7:0] store_load_data_in,
   output logic [7:0] host_rd_data_out,
   output logic [9:0] duty_out,
   output logic passthrough_active_out,
   output logic open_loop_out
);
   localparam int NREG = 10;
   if (olduty_pkg::CMD_BITS != 9 || olduty_pkg::DUTY_BITS != 10)
   begin : g_width_check
      $error("olduty_curve serves a 9-bit command only");
   end

   logic [7:0] reg_q [NREG];
   olduty_pkg::olduty_wr_type wr;
   olduty_pkg::olduty_param_type p;
   logic [8:0] cmd_m;
   logic [9:0] cmd_w, begin_w, halt_w, top_w, knee_w, ret_w;
   logic [9:0] max_curve, idle_full, next_duty, curve_now, out_mask;
   logic running, next_running, next_pt;

   // Store load wins over host so a reload cannot be half overwritten
   always_comb
   begin
      wr.en = store_load_en_in | host_wr_en_in;
      wr.addr = store_load_en_in ? store_load_addr_in : host_addr_in;
      wr.data = store_load_en_in ? store_load_data_in : host_wr_data_in;
   end

   generate
      for (genvar i = 0; i < NREG; i++)
      begin : g_reg
         always_ff @(posedge clk_in)
         begin
            if (reset_in)
            begin
               reg_q[i] <= olduty_pkg::REG_RESET;
            end
            else if (wr.en && wr.addr == olduty_pkg::ADDR_HALT + 8'(i))
            begin
               reg_q[i] <= wr.data;
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         host_rd_data_out <= 8'h00;
      end
      else if (host_rd_addr_in >= olduty_pkg::ADDR_HALT &&
               host_rd_addr_in <= olduty_pkg::ADDR_GAIN2_LO)
      begin
         host_rd_data_out <= reg_q[4'(host_rd_addr_in -
                                     olduty_pkg::ADDR_HALT)];
      end
      else
      begin
         host_rd_data_out <= 8'h00;
      end
   end

   always_comb
   begin
      p.keep_turning_mode = reg_q[0][olduty_pkg::KEEP_BIT];
      p.halt_threshold_code = reg_q[0][6:0];
      p.begin_threshold_code = reg_q[1];
      p.knee_point_code = reg_q[2];
      p.top_threshold_code = reg_q[3];
      p.floor_output_code = reg_q[4];
      p.passthrough_hysteresis = reg_q[5][3:0];
      p.first_gain_code = {reg_q[6], reg_q[7][7:2]};
      p.passthrough_above_top = reg_q[7][olduty_pkg::PASS_BIT];
      p.full_on_when_idle = reg_q[7][olduty_pkg::FULL_BIT];
      p.second_gain_code = {reg_q[8], reg_q[9][7:2]};
      p.open_loop_select = reg_q[9][olduty_pkg::OPEN_BIT];
   end

   always_comb
   begin
      case (cmd_lsb_drop_in)
         2'h0: cmd_m = speed_command_in;
         2'h1: cmd_m = speed_command_in & 9'h1fe;
         default: cmd_m = speed_command_in & 9'h1fc;
      endcase
      case (out_lsb_drop_in)
         2'h0: out_mask = 10'h3ff;
         2'h1: out_mask = 10'h3fe;
         default: out_mask = 10'h3fc;
      endcase
   end

   always_comb
   begin
      cmd_w = {1'b0, cmd_m};
      begin_w = {2'b00, p.begin_threshold_code};
      halt_w = {2'b00, p.halt_threshold_code, 1'b0};
      top_w = {2'b00, p.top_threshold_code} + olduty_pkg::TOP_OFFSET;
      knee_w = {1'b0, p.knee_point_code, 1'b0};
      ret_w = top_w - {4'h0, 5'({1'b0, p.passthrough_hysteresis} +
                                5'h01), 1'b0};
   end

   function automatic logic [9:0] curve_f(input logic [9:0] x,
                                          input logic [9:0] st,
                                          input logic [9:0] kn,
                                          input olduty_pkg::olduty_param_type q);
      logic [9:0] a;
      logic [9:0] b;
      logic [23:0] s1;
      logic [23:0] s2;
      logic [15:0] sum;
      a = 10'h000;
      b = 10'h000;
      if (x > st)
      begin
         // A knee at or below begin is misplaced and simply ignored
         if (kn != 10'h000 && kn > st && x > kn)
         begin
            a = kn - st;
            b = x - kn;
         end
         else
         begin
            a = x - st;
         end
      end
      s1 = 24'(a) * 24'(q.first_gain_code);
      s2 = 24'(b) * 24'(q.second_gain_code);
      sum = 16'(q.floor_output_code) + 16'(s1 >> olduty_pkg::GAIN_SHIFT) +
            16'(s2 >> olduty_pkg::GAIN_SHIFT);
      curve_f = (sum > 16'(olduty_pkg::DUTY_FULL)) ? olduty_pkg::DUTY_FULL :
                sum[9:0];
   endfunction

   always_comb
   begin
      curve_now = curve_f(cmd_w, begin_w, knee_w, p);
      max_curve = curve_f(top_w, begin_w, knee_w, p);
      idle_full = p.passthrough_above_top ? olduty_pkg::DUTY_FULL :
                  max_curve;
      next_pt = p.open_loop_select && p.passthrough_above_top &&
                (passthrough_active_out ? cmd_w >= ret_w :
                 cmd_w >= top_w);
      next_running = (cmd_w > begin_w) ? 1'b1 :
                     (cmd_w <= halt_w) ? 1'b0 : running;
   end

   always_comb
   begin
      if (!p.open_loop_select)
      begin
         next_duty = 10'h000;
      end
      else if (next_pt)
      begin
         next_duty = cmd_w;
      end
      else if (cmd_w == 10'h000)
      begin
         next_duty = p.full_on_when_idle ? idle_full :
                     p.keep_turning_mode ? 10'(p.floor_output_code) :
                     10'h000;
      end
      else if (cmd_w <= halt_w)
      begin
         if (p.keep_turning_mode)
         begin
            next_duty = p.full_on_when_idle ? idle_full :
                        10'(p.floor_output_code);
         end
         else
         begin
            next_duty = 10'h000;
         end
      end
      else if (cmd_w <= begin_w)
      begin
         // Band memory keeps a slowing motor turning without restart
         next_duty = (p.keep_turning_mode || running) ?
                     10'(p.floor_output_code) : 10'h000;
      end
      else
      begin
         next_duty = curve_now;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         duty_out <= 10'h000;
      end
      else
      begin
         duty_out <= next_duty & out_mask;
      end
   end

   always_ff @(posedge clk_in)
   begin
      if (reset_in)
      begin
         running <= 1'b0;
         passthrough_active_out <= 1'b0;
         open_loop_out <= 1'b0;
      end
      else
      begin
         running <= next_running;
         passthrough_active_out <= next_pt;
         open_loop_out <= p.open_loop_select;
      end
   end

   property p_saturate;
      @(posedge clk_in) disable iff (reset_in)
      duty_out <= olduty_pkg::DUTY_FULL;
   endproperty
   a_saturate: assert property (p_saturate)
      else $error("duty above full scale");

   property p_closed;
      @(posedge clk_in) disable iff (reset_in)
      !p.open_loop_select |=> duty_out == 10'h000;
   endproperty
   a_closed: assert property (p_closed)
      else $error("duty driven in closed-loop mode");

   property p_plain_low;
      @(posedge clk_in) disable iff (reset_in)
      (p.open_loop_select && !p.keep_turning_mode && !p.full_on_when_idle &&
       cmd_w <= halt_w && !next_pt) |=> duty_out == 10'h000;
   endproperty
   a_plain_low: assert property (p_plain_low)
      else $error("nonzero duty at or below halt");

   property p_keep;
      @(posedge clk_in) disable iff (reset_in)
      (p.open_loop_select && p.keep_turning_mode && !p.full_on_when_idle &&
       cmd_w <= begin_w && !next_pt && out_lsb_drop_in == 2'd0) |=>
      duty_out == 10'($past(p.floor_output_code));
   endproperty
   a_keep: assert property (p_keep)
      else $error("keep-turning did not give floor output");

   property p_pass;
      @(posedge clk_in) disable iff (reset_in)
      (p.open_loop_select && p.passthrough_above_top && cmd_w >= top_w &&
       out_lsb_drop_in == 2'd0) |=> duty_out == {1'b0, $past(cmd_m)};
   endproperty
   a_pass: assert property (p_pass)
      else $error("pass-through not following input");

   property p_exit;
      @(posedge clk_in) disable iff (reset_in)
      (passthrough_active_out && cmd_w < ret_w) |=> !passthrough_active_out;
   endproperty
   a_exit: assert property (p_exit)
      else $error("pass-through held below return point");

   property p_hold;
      @(posedge clk_in) disable iff (reset_in)
      (passthrough_active_out && p.passthrough_above_top &&
       p.open_loop_select && cmd_w >= ret_w) |=> passthrough_active_out;
   endproperty
   a_hold: assert property (p_hold)
      else $error("pass-through dropped inside hysteresis");

   property p_idle_full;
      @(posedge clk_in) disable iff (reset_in)
      (p.open_loop_select && p.full_on_when_idle &&
       p.passthrough_above_top && cmd_w == 10'h000) |=>
      duty_out == olduty_pkg::DUTY_FULL;
   endproperty
   a_idle_full: assert property (p_idle_full)
      else $error("idle command did not give full duty");

   property p_reg_rw;
      @(posedge clk_in) disable iff (reset_in)
      (host_wr_en_in && !store_load_en_in &&
       host_addr_in == olduty_pkg::ADDR_BEGIN) ##1
      (host_rd_addr_in == olduty_pkg::ADDR_BEGIN && !wr.en) |=>
      host_rd_data_out == $past(host_wr_data_in, 2);
   endproperty
   a_reg_rw: assert property (p_reg_rw)
      else $error("register readback mismatch");

   c_pass_enter: cover property (@(posedge clk_in) disable iff (reset_in)
      !passthrough_active_out ##1 passthrough_active_out);
   c_band_floor: cover property (@(posedge clk_in) disable iff (reset_in)
      running && cmd_w <= begin_w && cmd_w > halt_w &&
      !p.keep_turning_mode && p.floor_output_code != 8'h00);
   c_knee: cover property (@(posedge clk_in) disable iff (reset_in)
      p.open_loop_select && knee_w > begin_w && cmd_w > knee_w);
   c_sat: cover property (@(posedge clk_in) disable iff (reset_in)
      duty_out == olduty_pkg::DUTY_FULL && !passthrough_active_out);
endmodule
`default_nettype wire

// ---- hw/olduty_pkg.sv ----
`default_nettype none
package olduty_pkg;
   localparam int CMD_BITS = 9;
   localparam int DUTY_BITS = 10;
   localparam int GAIN_BITS = 14;
   localparam int GAIN_SHIFT = 10;
   localparam logic [9:0] DUTY_FULL = 10'h200;
   localparam logic [9:0] TOP_OFFSET = 10'h101;
   localparam logic [7:0] REG_RESET = 8'h00;
   localparam logic [7:0] ADDR_HALT = 8'h02;
   localparam logic [7:0] ADDR_BEGIN = 8'h03;
   localparam logic [7:0] ADDR_KNEE = 8'h04;
   localparam logic [7:0] ADDR_TOP = 8'h05;
   localparam logic [7:0] ADDR_FLOOR = 8'h06;
   localparam logic [7:0] ADDR_HYST = 8'h07;
   localparam logic [7:0] ADDR_GAIN1_HI = 8'h08;
   localparam logic [7:0] ADDR_GAIN1_LO = 8'h09;
   localparam logic [7:0] ADDR_GAIN2_HI = 8'h0a;
   localparam logic [7:0] ADDR_GAIN2_LO = 8'h0b;
   localparam int KEEP_BIT = 7;
   localparam int PASS_BIT = 1;
   localparam int FULL_BIT = 0;
   localparam int OPEN_BIT = 0;

   typedef struct packed {
      logic [6:0] halt_threshold_code;
      logic keep_turning_mode;
      logic [7:0] begin_threshold_code;
      logic [7:0] knee_point_code;
      logic [7:0] top_threshold_code;
      logic [7:0] floor_output_code;
      logic [3:0] passthrough_hysteresis;
      logic [13:0] first_gain_code;
      logic [13:0] second_gain_code;
      logic passthrough_above_top;
      logic full_on_when_idle;
      logic open_loop_select;
   } olduty_param_type;

   typedef struct packed {
      logic en;
      logic [7:0] addr;
      logic [7:0] data;
   } olduty_wr_type;
endpackage
`default_nettype wire

// ---- testbench/olduty_cmd_src.sv ----
`default_nettype none
// Speed command source; the bench calls send just after a rising edge
module olduty_cmd_src
(
   input wire logic clk_in,
   output logic [8:0] speed_command_out,
   output logic [1:0] cmd_lsb_drop_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial
   begin
      speed_command_out = 9'h000;
      cmd_lsb_drop_out = 2'h0;
   end
   // Rate code 0 up to 20 kHz, 1 near 40 kHz, 2 or 3 near 100 kHz
   task automatic send(input logic [8:0] value, input logic [1:0] rate);
      speed_command_out = value;
      cmd_lsb_drop_out = rate;
   endtask
endmodule
`default_nettype wire

// ---- testbench/testbench.sv ----
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clk_in = 1'b0;
   logic reset_in = 1'b1;
   logic [8:0] speed_command;
   logic [1:0] cmd_drop;
   logic [1:0] out_drop = 2'h0;
   logic wr_en = 1'b0;
   logic ld_en = 1'b0;
   logic [7:0] wr_addr = 8'h00;
   logic [7:0] wr_data = 8'h00;
   logic [7:0] rd_addr = 8'h00;
   logic [7:0] ld_data = 8'h00;
   logic [7:0] rd_data;
   logic [9:0] duty;
   logic pass_act;
   logic open_out;
   logic fire = 1'b0;
   logic run_st = 1'b0;
   logic pass_st = 1'b0;
   logic [8:0] cmd = 9'h000;
   logic [1:0] rate = 2'h0;
   logic [1:0] odrop = 2'h0;
   logic [12:0] notes[$];
   logic [7:0] shadow[16] = '{default: 8'h00};
   logic [31:0] rng = 32'h00018197;
   int n_mismatch = 0;
   int cmp_count = 0;
   logic [7:0] cfg_a[10] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07,
      8'h08, 8'h09, 8'h0a, 8'h0b};
   logic [7:0] cfg_d[10] = '{8'h17, 8'h66, 8'h00, 8'hcc, 8'h33, 8'h04,
      8'h13, 8'h64, 8'h00, 8'h01};
   // Thresholds are crossed upward, then back down through the band
   logic [8:0] seq[14] = '{9'h000, 9'h02e, 9'h02f, 9'h066, 9'h12c, 9'h066,
      9'h02f, 9'h01e, 9'h1cc, 9'h1cd, 9'h1ff, 9'h1c3, 9'h1c2, 9'h000};

   always #5 clk_in = ~clk_in;

   olduty_cmd_src olduty_cmd_src_inst
   (
      .clk_in(clk_in),
      .speed_command_out(speed_command),
      .cmd_lsb_drop_out(cmd_drop)
   );

   olduty_curve olduty_curve_inst
   (
      .clk_in(clk_in),
      .reset_in(reset_in),
      .speed_command_in(speed_command),
      .cmd_lsb_drop_in(cmd_drop),
      .out_lsb_drop_in(out_drop),
      .host_wr_en_in(wr_en),
      .host_addr_in(wr_addr),
      .host_wr_data_in(wr_data),
      .host_rd_addr_in(rd_addr),
      .store_load_en_in(ld_en),
      .store_load_addr_in(wr_addr),
      .store_load_data_in(ld_data),
      .host_rd_data_out(rd_data),
      .duty_out(duty),
      .passthrough_active_out(pass_act),
      .open_loop_out(open_out)
   );

   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction

   function automatic logic [1:0] lm(input logic [1:0] d);
      return (d == 2'h0) ? 2'h0 : ((d == 2'h1) ? 2'h1 : 2'h3);
   endfunction

   function automatic int curve(input int x);
      int beg, kn, a, b, v;
      beg = shadow[3];
      kn = 2 * shadow[4];
      a = x - beg;
      b = 0;
      if (kn > beg && x > kn)
      begin
         a = kn - beg;
         b = x - kn;
      end
      v = shadow[6] + ((a * int'({shadow[8], shadow[9][7:2]})) >> 10)
         + ((b * int'({shadow[10], shadow[11][7:2]})) >> 10);
      return (v > 512) ? 512 : v;
   endfunction

   function automatic logic [10:0] ref_step(input int c);
      int halt, top, ret, idle, d;
      logic keep, pass, full;
      keep = shadow[2][7];
      pass = shadow[9][1];
      full = shadow[9][0];
      halt = 2 * shadow[2][6:0];
      top = shadow[5] + 257;
      ret = top - 2 * (shadow[7][3:0] + 1);
      idle = pass ? 512 : curve(top);
      if (c > shadow[3])
         run_st = 1'b1;
      else if (c <= halt)
         run_st = 1'b0;
      pass_st = pass && shadow[11][0]
         && (c >= top || (pass_st && c >= ret));
      if (!shadow[11][0])
         d = 0;
      else if (pass_st)
         d = c;
      else if (c == 0)
         d = full ? idle : (keep ? shadow[6] : 0);
      else if (c <= halt)
         d = keep ? (full ? idle : shadow[6]) : 0;
      else if (c <= shadow[3])
         d = (keep || run_st) ? shadow[6] : 0;
      else
         d = curve(c);
      return {pass_st, d[9:0]};
   endfunction

   task automatic check(input logic [12:0] seen, input logic [12:0] exp);
      cmp_count++;
      if (seen !== exp)
      begin
         n_mismatch++;
         $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic give_verdict();
      if (n_mismatch == 0 && cmp_count > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask

   // One clock cycle: k 0 none, 1 duty note, 2 read note
   task automatic cyc(input logic [1:0] k, input logic w, input logic st,
         input logic [7:0] a, input logic [7:0] dt);
      logic [10:0] e;
      logic [7:0] rv;
      @(posedge clk_in);
      #1;
      olduty_cmd_src_inst.send(cmd, rate);
      out_drop = odrop;
      wr_en = w;
      ld_en = st;
      wr_addr = a;
      rd_addr = a;
      ld_data = dt;
      wr_data = st ? ~dt : dt;
      // Model sees old register values, as the edge does
      e = ref_step(cmd & ~{7'h00, lm(rate)});
      rv = (a >= 8'h02 && a <= 8'h0b) ? shadow[a[3:0]] : 8'h00;
      if (k == 2'h1)
         notes.push_back({1'b0, shadow[11][0], e[10],
            e[9:0] & ~{8'h00, lm(odrop)}});
      if (k == 2'h2)
         notes.push_back({5'h10, rv});
      fire = (k != 2'h0);
      if ((w || st) && a >= 8'h02 && a <= 8'h0b)
         shadow[a[3:0]] = dt;
   endtask

   task automatic wr(input logic [7:0] a, input logic [7:0] dt);
      cyc(2'h0, 1'b1, 1'b0, a, dt);
   endtask

   task automatic run(input logic [8:0] c);
      cmd = c;
      cyc(2'h1, 1'b0, 1'b0, 8'h00, 8'h00);
   endtask

   always
   begin
      @(posedge clk_in);
      if (fire === 1'b1)
      begin
         #2;
         if (notes[0][12])
            check({5'h10, rd_data}, notes.pop_front());
         else
            check({1'b0, open_out, pass_act, duty},
               notes.pop_front());
      end
   end

   initial
   begin
      for (int i = 0; i < 20000; i++)
         @(posedge clk_in);
      n_mismatch++;
      give_verdict();
   end

   initial
   begin
      for (int i = 0; i < 5; i++)
         @(posedge clk_in);
      #1;
      reset_in = 1'b0;
      for (int a = 1; a < 13; a++)
         cyc(2'h2, 1'b0, 1'b0, 8'(a), 8'h00);
      for (int a = 1; a < 13; a++)
      begin
         rng = xs(rng);
         wr(8'(a), rng[7:0]);
      end
      for (int a = 1; a < 13; a++)
         cyc(2'h2, 1'b0, 1'b0, 8'(a), 8'h00);
      cyc(2'h0, 1'b1, 1'b1, 8'h03, 8'h5a);
      cyc(2'h2, 1'b0, 1'b0, 8'h03, 8'h00);
      wr(8'h03, 8'ha5);
      cyc(2'h2, 1'b0, 1'b0, 8'h03, 8'h00);
      for (int i = 0; i < 10; i++)
         cyc(2'h0, 1'b0, 1'b1, cfg_a[i], cfg_d[i]);
      run(9'h0c8);
      for (int m = 0; m < 8; m++)
      begin
         wr(8'h02, {m[0], 7'h17});
         wr(8'h09, {6'h19, m[2:1]});
         foreach (seq[i])
            run(seq[i]);
      end
      wr(8'h04, 8'h80);
      wr(8'h0a, 8'h15);
      wr(8'h0b, 8'hf1);
      foreach (seq[i])
         run(seq[i] | 9'h100);
      for (int i = 0; i < 300; i++)
      begin
         rng = xs(rng);
         rate = rng[1:0];
         odrop = rng[3:2];
         if (rng[8:4] == 5'h00)
            wr(8'h02, {rng[9], 7'h17});
         if (rng[8:4] == 5'h01)
            wr(8'h09, {6'h19, rng[11:10]});
         run(rng[28:20]);
      end
      wr(8'h0b, 8'hf0);
      run(9'h12c);
      wr(8'h0b, 8'hf1);
      run(9'h000);
      cyc(2'h0, 1'b0, 1'b0, 8'h00, 8'h00);
      cyc(2'h0, 1'b0, 1'b0, 8'h00, 8'h00);
      give_verdict();
   end
endmodule
`default_nettype wire
